// ==== bench/pin_interrupt_router_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module pin_interrupt_router_bench;
    typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic e;} prtr_row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [63:0] lvl_req = 64'h0000_0000_0000_0000;
    wire logic [63:0] port_pins;
    logic [4:0] chans;
    logic irq;
    logic [31:0] rd_v;
    logic err_v;
    int errors = 0;
    int total_checks = 0;
    wire logic [31:0] chan_w = {27'h000_0000, chans};
    wire logic [31:0] irq_w = {31'h0000_0000, irq};
    // Write rows carry write data, read rows the value expected back
    prtr_row_t rows [19] = '{
        '{1'b0, 12'h000, 32'h0000_0000, 1'b0}, '{1'b1, 12'h000, 32'h0000_00F0, 1'b0},
        '{1'b1, 12'h000, 32'h0000_0003, 1'b0}, '{1'b0, 12'h004, 32'h0000_00F3, 1'b0},
        '{1'b1, 12'h004, 32'h0000_0011, 1'b0}, '{1'b0, 12'h000, 32'h0000_00E2, 1'b0},
        '{1'b1, 12'h010, 32'h0000_00FF, 1'b0}, '{1'b1, 12'h014, 32'h0000_000F, 1'b0},
        '{1'b0, 12'h010, 32'h0000_00F0, 1'b0}, '{1'b1, 12'h0D8, 32'h0000_0003, 1'b0},
        '{1'b1, 12'h0DC, 32'h0000_0001, 1'b0}, '{1'b0, 12'h0D8, 32'h0000_0002, 1'b0},
        '{1'b1, 12'h08C, 32'h0000_0201, 1'b0}, '{1'b0, 12'h08C, 32'h0000_0201, 1'b0},
        '{1'b0, 12'h028, 32'h0000_0000, 1'b1}, '{1'b1, 12'h180, 32'h0000_0005, 1'b1},
        '{1'b0, 12'h180, 32'h0000_0000, 1'b1}, '{1'b0, 12'h002, 32'h0000_0000, 1'b1},
        '{1'b0, 12'h144, 32'h0000_0000, 1'b0}
    };

    always #5 pclk = ~pclk;

    prtr_pin_model pins (.pclk(pclk), .lvl_req(lvl_req), .port_pins(port_pins));

    prtr_top #(.NHALF(8)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_pins(port_pins), .pin_irq_channels(chans), .irq(irq)
    );

    task automatic check(input string n, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, exp, got);
        end
    endtask

    // Request held until pready is sampled high; one idle edge before the next setup
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd_v, err_v);
    endtask

    task automatic rd(input string n, input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000, rd_v, err_v);
        check(n, rd_v, x);
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        $display("watchdog expired");
        test_done;
    end

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("chan_rst", chan_w, 32'h0000_0000);
        check("pready", {31'h0000_0000, pready}, 32'h0000_0001);
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d, rd_v, err_v);
            if (!rows[i].w) check("reg_rd", rd_v, rows[i].d);
            check("slverr", {31'h0000_0000, err_v}, {31'h0000_0000, rows[i].e});
        end
        $display("register rows done");
        // Channel 1 and channel 4 both watch half port 2
        wr(12'h04C, 32'h0000_0002);
        wr(12'h050, 32'h0000_0001);
        wr(12'h058, 32'h0000_0002);
        wr(12'h10C, 32'h0200_0000);
        wr(12'h100, 32'h0100_0000);
        repeat (8) @(posedge pclk);
        rd("pinstate", 12'h060, 32'h0000_0002);
        rd("lvl_latch", 12'h064, 32'h0000_0002);
        lvl_req <= 64'h0000_0000_0003_0000;
        repeat (8) @(posedge pclk);
        rd("edge_latch", 12'h064, 32'h0000_0001);
        check("or_chan", chan_w, 32'h0000_0010);
        wr(12'h040, 32'h0000_0001);
        repeat (3) @(posedge pclk);
        check("both_chan", chan_w, 32'h0000_0012);
        rd("req", 12'h048, 32'h0000_0001);
        lvl_req <= 64'h0000_0000_0000_0000;
        repeat (8) @(posedge pclk);
        rd("sticky", 12'h064, 32'h0000_0003);
        check("lvl_drop", chan_w, 32'h0000_0002);
        rd("stat", 12'h140, 32'h0000_0012);
        check("irq_masked", irq_w, 32'h0000_0000);
        wr(12'h144, 32'h0000_0002);
        check("irq_on", irq_w, 32'h0000_0001);
        wr(12'h048, 32'h0000_0001);
        repeat (4) @(posedge pclk);
        check("chan_clr", chan_w, 32'h0000_0000);
        wr(12'h140, 32'h0000_0012);
        rd("stat_clr", 12'h140, 32'h0000_0000);
        check("irq_off", irq_w, 32'h0000_0000);
        $display("pin tests done");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd("rst_mask", 12'h040, 32'h0000_0000);
        rd("rst_assign", 12'h04C, 32'h0000_0000);
        $display("reset test done");
        test_done;
    end
endmodule
`default_nettype wire

// ==== bench/prtr_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module prtr_pin_model (
    // Clock
    input wire logic pclk,
    // Levels the bench wants on the pins
    input wire logic [63:0] lvl_req,
    // Pins toward the block
    output logic [63:0] port_pins
);
    // External pins hold each level for many cycles, well above the 2 cycle minimum
    always @(posedge pclk) begin
        port_pins <= lvl_req;
    end
endmodule
`default_nettype wire

// ==== logic/prtr_lane.sv ====
`timescale 1ns/1ps
`default_nettype none
module prtr_lane (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pin and configuration
    input wire logic pin_lvl,
    input wire logic edge_mode,
    input wire logic invert,
    input wire logic clr,
    // State
    output logic active,
    output logic latch
);
    logic prev_r;
    logic latch_r;
    logic latch_nxt;
    logic rise;

    assign active = pin_lvl ^ invert;
    assign rise = active & ~prev_r;
    // Edge latch: set beats a same-cycle clear; level mode follows the pin
    assign latch_nxt = edge_mode ? (rise | (latch_r & ~clr)) : active;
    assign latch = latch_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_r <= 1'b0;
            latch_r <= 1'b0;
        end else begin
            prev_r <= active;
            latch_r <= latch_nxt;
        end
    end

    chk_latch_hold: assert property (@(posedge pclk) disable iff (!presetn)
        edge_mode && latch_r && !clr && $stable(edge_mode) |=> latch_r)
        else $error("edge latch dropped without clear");

    chk_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
        edge_mode && rise |=> latch_r)
        else $error("new edge lost to a clear");

    chk_clr_drops: assert property (@(posedge pclk) disable iff (!presetn)
        edge_mode && clr && !rise |=> !latch_r)
        else $error("edge latch survived a clear");

    chk_level_follow: assert property (@(posedge pclk) disable iff (!presetn)
        !edge_mode |=> latch_r == $past(active))
        else $error("level latch did not follow the pin");
endmodule
`default_nettype wire

// ==== logic/prtr_pkg.sv ====
`default_nettype none
package prtr_pkg;
    // Channel layout
    localparam int NCH = 5;
    localparam int LANES = 32;
    localparam int HALF_PINS = 8;
    localparam int HALF_IDX_LSB = 3;
    localparam int FIELD_W = 8;
    localparam int NHALF_DEF = 8;
    localparam int AW = 12;
    localparam int CH_SHIFT = 6;
    localparam int CH_SEL_W = AW - CH_SHIFT;
    // Per-channel register offsets
    localparam logic [5:0] OFF_MSK_SET = 6'h00;
    localparam logic [5:0] OFF_MSK_CLR = 6'h04;
    localparam logic [5:0] OFF_REQ = 6'h08;
    localparam logic [5:0] OFF_ASSIGN = 6'h0C;
    localparam logic [5:0] OFF_EDGE_SET = 6'h10;
    localparam logic [5:0] OFF_EDGE_CLR = 6'h14;
    localparam logic [5:0] OFF_INV_SET = 6'h18;
    localparam logic [5:0] OFF_INV_CLR = 6'h1C;
    localparam logic [5:0] OFF_PINSTATE = 6'h20;
    localparam logic [5:0] OFF_LATCH = 6'h24;
    // Global interrupt registers
    localparam logic [AW-1:0] ADDR_IRQ_STAT = 12'h140;
    localparam logic [AW-1:0] ADDR_IRQ_MASK = 12'h144;
    // Reset values
    localparam logic [31:0] RST_MASK = 32'h0000_0000;
    localparam logic [31:0] RST_EDGE = 32'h0000_0000;
    localparam logic [31:0] RST_INV = 32'h0000_0000;
    localparam logic [31:0] RST_ASSIGN = 32'h0000_0000;
    localparam logic [NCH-1:0] RST_STAT = 5'h00;
    localparam logic [NCH-1:0] RST_IMASK = 5'h00;
endpackage
`default_nettype wire

// ==== logic/prtr_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module prtr_sync #(
    parameter int WIDTH = 64
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Asynchronous pins in, filtered levels out
    input wire logic [WIDTH-1:0] pin_async,
    output logic [WIDTH-1:0] pin_sync
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] out_r;
    logic [WIDTH-1:0] out_nxt;

    if (WIDTH < 1) begin : g_bad_width
        $error("WIDTH must be at least 1");
    end

    // A change is accepted only once the second and third stages agree
    assign out_nxt = (s2_r & s3_r) | (out_r & (s2_r ^ s3_r));
    assign pin_sync = out_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            out_r <= '0;
        end else begin
            s1_r <= pin_async;
            s2_r <= s1_r;
            s3_r <= s2_r;
            out_r <= out_nxt;
        end
    end
endmodule
`default_nettype wire

// ==== logic/prtr_top.sv ====
// Behaviour
// - Every pin can request an interrupt by edge or by level, with programmable polarity.
// - Detection works straight from the pins, whatever their general-purpose I/O setup.
// - Five channel outputs carry only requests that come from pins.
// - Each channel serves up to 32 pins and ORs their requests into one.
// - Pins are routed to channels eight at a time, any half port to any channel.
// - Each channel has 32-bit registers for assignment, masking, identification and clearing.
// - Pin states and latches read back whatever the mask holds.
// - Mask, edge and invert registers have set and clear aliases where ones act and zeros leave bits alone.
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module prtr_top #(
    parameter int NHALF = prtr_pkg::NHALF_DEF
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [prtr_pkg::AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Port pins
    input wire logic [NHALF*prtr_pkg::HALF_PINS-1:0] port_pins,
    // Channel requests and summary interrupt
    output logic [prtr_pkg::NCH-1:0] pin_irq_channels,
    output logic irq
);
    localparam int NPIN = NHALF * prtr_pkg::HALF_PINS;
    localparam int HW = $clog2(NHALF);
    localparam int NCH = prtr_pkg::NCH;
    localparam int LANES = prtr_pkg::LANES;

    if (NHALF < 2 || NHALF > 256) begin : g_bad_nhalf
        $error("NHALF must lie between 2 and 256");
    end

    // Address decode
    function automatic logic ch_hit(input logic [prtr_pkg::AW-1:0] a, input int c,
                                    input logic [5:0] off);
        ch_hit = (a[prtr_pkg::AW-1:prtr_pkg::CH_SHIFT] == prtr_pkg::CH_SEL_W'(c))
                 && (a[5:0] == off);
    endfunction

    logic [prtr_pkg::CH_SEL_W-1:0] ch_sel;
    logic [5:0] woff;
    logic ch_ok;
    logic off_ok;
    logic hit_stat;
    logic hit_imask;
    logic map_ok;
    logic acc;
    logic wr_en;
    logic setup_rd;

    assign ch_sel = paddr[prtr_pkg::AW-1:prtr_pkg::CH_SHIFT];
    assign woff = paddr[5:0];
    assign ch_ok = ch_sel < prtr_pkg::CH_SEL_W'(NCH);
    assign off_ok = (woff[1:0] == 2'b00) && (woff <= prtr_pkg::OFF_LATCH);
    assign hit_stat = paddr == prtr_pkg::ADDR_IRQ_STAT;
    assign hit_imask = paddr == prtr_pkg::ADDR_IRQ_MASK;
    assign map_ok = (ch_ok && off_ok) || hit_stat || hit_imask;
    assign acc = psel && penable;
    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = acc && !map_ok;
    assign wr_en = acc && pwrite && map_ok;
    assign setup_rd = psel && !penable && !pwrite;

    // Pin synchroniser, fed directly by the pads
    logic [NPIN-1:0] pin_s;

    prtr_sync #(
        .WIDTH(NPIN)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_async(port_pins),
        .pin_sync(pin_s)
    );

    // Per-channel registers
    logic [31:0] mask_r [NCH];
    logic [31:0] edge_r [NCH];
    logic [31:0] inv_r [NCH];
    logic [31:0] asg_r [NCH];
    logic [31:0] mask_nxt [NCH];
    logic [31:0] edge_nxt [NCH];
    logic [31:0] inv_nxt [NCH];
    logic [31:0] asg_nxt [NCH];
    logic [31:0] clr_w [NCH];
    wire [31:0] latch_w [NCH];
    wire [31:0] act_w [NCH];
    logic [NCH-1:0] chan_req;
    logic [NCH-1:0] chan_r;

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        logic w_mset;
        logic w_mclr;
        logic w_eset;
        logic w_eclr;
        logic w_iset;
        logic w_iclr;
        logic w_asg;
        logic w_clr;

        assign w_mset = wr_en && ch_hit(paddr, c, prtr_pkg::OFF_MSK_SET);
        assign w_mclr = wr_en && ch_hit(paddr, c, prtr_pkg::OFF_MSK_CLR);
        assign w_eset = wr_en && ch_hit(paddr, c, prtr_pkg::OFF_EDGE_SET);
        assign w_eclr = wr_en && ch_hit(paddr, c, prtr_pkg::OFF_EDGE_CLR);
        assign w_iset = wr_en && ch_hit(paddr, c, prtr_pkg::OFF_INV_SET);
        assign w_iclr = wr_en && ch_hit(paddr, c, prtr_pkg::OFF_INV_CLR);
        assign w_asg = wr_en && ch_hit(paddr, c, prtr_pkg::OFF_ASSIGN);
        // Both the request and the latch view clear pending latches
        assign w_clr = wr_en && (ch_hit(paddr, c, prtr_pkg::OFF_REQ)
                                 || ch_hit(paddr, c, prtr_pkg::OFF_LATCH));

        assign mask_nxt[c] = w_mset ? (mask_r[c] | pwdata) :
                             w_mclr ? (mask_r[c] & ~pwdata) : mask_r[c];
        assign edge_nxt[c] = w_eset ? (edge_r[c] | pwdata) :
                             w_eclr ? (edge_r[c] & ~pwdata) : edge_r[c];
        assign inv_nxt[c] = w_iset ? (inv_r[c] | pwdata) :
                            w_iclr ? (inv_r[c] & ~pwdata) : inv_r[c];
        assign asg_nxt[c] = w_asg ? pwdata : asg_r[c];
        assign clr_w[c] = w_clr ? pwdata : 32'h0000_0000;

        for (genvar l = 0; l < LANES; l++) begin : g_lane
            logic [HW-1:0] hsel;
            logic lane_pin;

            // Each byte of the assignment register names the half port of eight lanes
            assign hsel = asg_r[c][prtr_pkg::FIELD_W*(l/prtr_pkg::HALF_PINS) +: HW];
            assign lane_pin = (32'(hsel) < NHALF) ?
                pin_s[{hsel, prtr_pkg::HALF_IDX_LSB'(l % prtr_pkg::HALF_PINS)}] :
                1'b0;

            prtr_lane u_lane (
                .pclk(pclk),
                .presetn(presetn),
                .pin_lvl(lane_pin),
                .edge_mode(edge_r[c][l]),
                .invert(inv_r[c][l]),
                .clr(clr_w[c][l]),
                .active(act_w[c][l]),
                .latch(latch_w[c][l])
            );
        end

        assign chan_req[c] = |(latch_w[c] & mask_r[c]);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int c = 0; c < NCH; c++) begin
                mask_r[c] <= prtr_pkg::RST_MASK;
                edge_r[c] <= prtr_pkg::RST_EDGE;
                inv_r[c] <= prtr_pkg::RST_INV;
                asg_r[c] <= prtr_pkg::RST_ASSIGN;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                mask_r[c] <= mask_nxt[c];
                edge_r[c] <= edge_nxt[c];
                inv_r[c] <= inv_nxt[c];
                asg_r[c] <= asg_nxt[c];
            end
        end
    end

    // Channel outputs and summary interrupt
    logic [NCH-1:0] stat_r;
    logic [NCH-1:0] stat_nxt;
    logic [NCH-1:0] imask_r;
    logic [NCH-1:0] imask_nxt;
    logic [NCH-1:0] stat_clr;

    assign stat_clr = (wr_en && hit_stat) ? pwdata[NCH-1:0] : '0;
    // A channel still requesting keeps its status bit set through a clear
    assign stat_nxt = (stat_r & ~stat_clr) | chan_r;
    assign imask_nxt = (wr_en && hit_imask) ? pwdata[NCH-1:0] : imask_r;
    assign pin_irq_channels = chan_r;
    assign irq = |(stat_r & imask_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_r <= '0;
            stat_r <= prtr_pkg::RST_STAT;
            imask_r <= prtr_pkg::RST_IMASK;
        end else begin
            chan_r <= chan_req;
            stat_r <= stat_nxt;
            imask_r <= imask_nxt;
        end
    end

    // Read path, sampled in the setup phase so prdata is a flop output
    logic [31:0] ch_rd;
    logic [31:0] rd_val;
    logic [31:0] prdata_r;
    logic [2:0] ci;

    assign ci = ch_ok ? ch_sel[2:0] : 3'h0;

    always_comb begin
        ch_rd = 32'h0000_0000;
        unique case (woff)
            prtr_pkg::OFF_MSK_SET,
            prtr_pkg::OFF_MSK_CLR: ch_rd = mask_r[ci];
            prtr_pkg::OFF_REQ: ch_rd = latch_w[ci] & mask_r[ci];
            prtr_pkg::OFF_ASSIGN: ch_rd = asg_r[ci];
            prtr_pkg::OFF_EDGE_SET,
            prtr_pkg::OFF_EDGE_CLR: ch_rd = edge_r[ci];
            prtr_pkg::OFF_INV_SET,
            prtr_pkg::OFF_INV_CLR: ch_rd = inv_r[ci];
            prtr_pkg::OFF_PINSTATE: ch_rd = act_w[ci];
            prtr_pkg::OFF_LATCH: ch_rd = latch_w[ci];
            default: ch_rd = 32'h0000_0000;
        endcase
    end

    assign rd_val = hit_stat ? 32'(stat_r) :
                    hit_imask ? 32'(imask_r) :
                    (ch_ok && off_ok) ? ch_rd : 32'h0000_0000;
    assign prdata = prdata_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup_rd) begin
            prdata_r <= rd_val;
        end
    end

    // Checks
    chk_chan_or: assert property (@(posedge pclk) disable iff (!presetn)
        (|(latch_w[4] & mask_r[4])) |=> pin_irq_channels[4])
        else $error("channel 4 missed a masked latch");

    chk_chan_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (mask_r[1] == 32'h0000_0000) |=> !pin_irq_channels[1])
        else $error("fully masked channel raised a request");

    chk_mask_set: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == 12'h000 |=> (mask_r[0] & $past(pwdata)) == $past(pwdata))
        else $error("mask set alias did not set bits");

    chk_mask_clr: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == 12'h004
        |=> mask_r[0] == ($past(mask_r[0]) & ~$past(pwdata)))
        else $error("mask clear alias wrong");

    chk_edge_set: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == 12'h050
        |=> edge_r[1] == ($past(edge_r[1]) | $past(pwdata)))
        else $error("edge set alias wrong");

    chk_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        acc && paddr == 12'h028 |-> pslverr)
        else $error("unmapped address not refused");

    chk_rd_latch: assert property (@(posedge pclk) disable iff (!presetn)
        setup_rd && paddr == 12'h064 ##1 acc |-> prdata == $past(latch_w[1]))
        else $error("latch read does not match state");

    chk_stat_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        stat_r[1] && !(wr_en && hit_stat && pwdata[1]) |=> stat_r[1])
        else $error("status bit lost without clear");

    chk_stat_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
        chan_r[1] |=> stat_r[1])
        else $error("requesting channel lost its status bit");

    chk_stat_w1c: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && hit_stat && pwdata[1] && !chan_r[1] |=> !stat_r[1])
        else $error("status bit not cleared by a one");

    chk_irq_on: assert property (@(posedge pclk) disable iff (!presetn)
        stat_r[1] && imask_r[1] |-> irq)
        else $error("unmasked status did not raise irq");

    chk_irq_off: assert property (@(posedge pclk) disable iff (!presetn)
        (stat_r & imask_r) == 5'h00 |-> !irq)
        else $error("irq high with nothing unmasked");

    chk_imask_load: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && hit_imask
        |=> 32'(imask_r) == ($past(pwdata) & 32'h0000_001F))
        else $error("interrupt mask write wrong");

    chk_pready_high: assert property (@(posedge pclk) disable iff (!presetn)
        acc |-> pready)
        else $error("access not answered at once");

    chk_err_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !acc |-> !pslverr)
        else $error("error flag outside an access");

    chk_wr_refused: assert property (@(posedge pclk) disable iff (!presetn)
        acc && pwrite && !map_ok
        |=> mask_r[0] == $past(mask_r[0]) && imask_r == $past(imask_r))
        else $error("refused write changed a register");

    chk_rd_refused: assert property (@(posedge pclk) disable iff (!presetn)
        setup_rd && !map_ok ##1 acc |-> prdata == 32'h0000_0000)
        else $error("refused read returned data");

    chk_mask_keep: assert property (@(posedge pclk) disable iff (!presetn)
        !wr_en |=> mask_r[0] == $past(mask_r[0]))
        else $error("mask changed without a write");

    chk_edge_clr: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == 12'h014
        |=> edge_r[0] == ($past(edge_r[0]) & ~$past(pwdata)))
        else $error("edge clear alias wrong");

    chk_inv_set: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == 12'h0D8
        |=> inv_r[3] == ($past(inv_r[3]) | $past(pwdata)))
        else $error("invert set alias wrong");

    chk_inv_clr: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == 12'h0DC
        |=> inv_r[3] == ($past(inv_r[3]) & ~$past(pwdata)))
        else $error("invert clear alias wrong");

    chk_asg_load: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == 12'h08C |=> asg_r[2] == $past(pwdata))
        else $error("assignment write wrong");

    chk_chan_low: assert property (@(posedge pclk) disable iff (!presetn)
        !(|(latch_w[4] & mask_r[4])) |=> !pin_irq_channels[4])
        else $error("channel 4 requested with nothing pending");

    chk_rd_mask: assert property (@(posedge pclk) disable iff (!presetn)
        setup_rd && paddr == 12'h004 ##1 acc |-> prdata == $past(mask_r[0]))
        else $error("mask read does not match state");

    chk_rd_pins: assert property (@(posedge pclk) disable iff (!presetn)
        setup_rd && paddr == 12'h060 ##1 acc |-> prdata == $past(act_w[1]))
        else $error("pin state read does not match state");
endmodule
`default_nettype wire
